// [verilog/matrix_select_and_virtual_io.sv]
/*
 * Connection matrix selectors for outputs 67..94, eight serially
 * written virtual matrix inputs and a serial read view of the image
 * and of the macrocell outputs, behind a two-wire serial target.
 * Assumes nvm_image is stable and nvm_loaded pulses once after power-up.
 */
`timescale 1ns/1ps
module matrix_select_and_virtual_io (
    input wire logic sys_clk, // 20 MHz system clock
    input wire logic reset, // async reset, active high
    input wire logic scl_in, // serial clock pin level
    input wire logic sda_in, // serial data pin level
    output logic sda_out, // serial data drive value
    output logic sda_oe, // serial data drive enable
    input wire logic [639:0] nvm_image, // configuration image
    input wire logic nvm_loaded, // pulse: image loaded
    input wire logic [63:0] macrocell_out, // macrocell outputs
    output logic [7:0] virtual_inputs, // virtual matrix inputs
    output logic [27:0] route_bus, // matrix outputs 67..94
    output logic byte_cell_in1, // third byte cell input one
    output logic wide_cell_in2, // wide cell input two
    output logic wide_cell_in3, // wide cell input three
    output logic fast_comparator_zero_pd, // comparator 0 power-down
    output logic fast_comparator_one_pd, // comparator 1 power-down
    output logic delay_edge_in, // programmable delay input
    output logic oscillator_zero_en, // oscillator 0 enable
    output logic oscillator_one_en, // oscillator 1 enable
    output logic temp_sensor_pd, // temperature sensor power-down
    output logic bandgap_reference_pd // bandgap power-down
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        matrix_io_pkg::link_state_e st;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic ptr_ok;
        logic rw;
        logic sda_drv;
        logic [7:0] virt;
        logic scl_q;
        logic sda_q;
    } ctl_s;

    ctl_s c_r;
    ctl_s c_nxt;

    logic [1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic [63:0] mtx_in;
    logic [7:0] rd_byte;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    pin_sync #(
        .WIDTH(2)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin_in({scl_in, sda_in}),
        .pin_sync_q(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // ----------------------------------------------------------------
    // matrix inputs with the virtual bits spliced in
    // ----------------------------------------------------------------
    always_comb
    begin
        mtx_in = macrocell_out;
        mtx_in[matrix_io_pkg::VIRT_MATRIX_IN +: matrix_io_pkg::VIRT_W] =
            c_r.virt;
    end

    // ----------------------------------------------------------------
    // selectors
    // ----------------------------------------------------------------
    for (genvar g = 0; g < matrix_io_pkg::NUM_FIELDS; g++)
    begin : g_route
        localparam int FIELD = matrix_io_pkg::FIRST_FIELD + g;
        route_mux #(
            .SEL_W(matrix_io_pkg::FIELD_W)
        ) u_mux (
            .sys_clk(sys_clk),
            .reset(reset),
            .sel(nvm_image[FIELD*matrix_io_pkg::FIELD_W +:
                matrix_io_pkg::FIELD_W]),
            .matrix_in(mtx_in),
            .route_q(route_bus[g])
        );
    end

    localparam int F0 = matrix_io_pkg::FIRST_FIELD;

    assign byte_cell_in1 =
        route_bus[matrix_io_pkg::MO_BYTE_CELL_IN1 - F0];
    assign wide_cell_in2 =
        route_bus[matrix_io_pkg::MO_WIDE_IN2 - F0];
    assign wide_cell_in3 =
        route_bus[matrix_io_pkg::MO_WIDE_IN3 - F0];
    assign fast_comparator_zero_pd =
        route_bus[matrix_io_pkg::MO_CMP0_PD - F0];
    assign fast_comparator_one_pd =
        route_bus[matrix_io_pkg::MO_CMP1_PD - F0];
    assign delay_edge_in =
        route_bus[matrix_io_pkg::MO_PDLY_IN - F0];
    assign oscillator_zero_en =
        route_bus[matrix_io_pkg::MO_OSCILLATOR_ZERO_EN - F0];
    assign oscillator_one_en =
        route_bus[matrix_io_pkg::MO_OSCILLATOR_ONE_EN - F0];
    assign temp_sensor_pd =
        route_bus[matrix_io_pkg::MO_TEMP_PD - F0];
    assign bandgap_reference_pd =
        route_bus[matrix_io_pkg::MO_BG_PD - F0];

    // ----------------------------------------------------------------
    // read data: image below the snapshot, live view inside it
    // ----------------------------------------------------------------
    always_comb
    begin
        if (c_r.ptr < matrix_io_pkg::SNAP_BYTE_LO)
            rd_byte = nvm_image[{c_r.ptr[6:0], 3'h0} +: 8];
        else if (c_r.ptr <= matrix_io_pkg::SNAP_BYTE_HI)
            rd_byte = mtx_in[{c_r.ptr[2:0], 3'h0} +: 8];
        else
            rd_byte = 8'h00;
    end

    // ----------------------------------------------------------------
    // bus events
    // ----------------------------------------------------------------
    assign scl_rise = scl_s & ~c_r.scl_q;
    assign scl_fall = ~scl_s & c_r.scl_q;
    assign start_det = scl_s & c_r.scl_q & c_r.sda_q & ~sda_s;
    assign stop_det = scl_s & c_r.scl_q & ~c_r.sda_q & sda_s;

    // ----------------------------------------------------------------
    // serial target
    // ----------------------------------------------------------------
    always_comb
    begin
        c_nxt = c_r;
        c_nxt.scl_q = scl_s;
        c_nxt.sda_q = sda_s;

        // power-up load first, so a write in the same cycle wins
        if (nvm_loaded)
            c_nxt.virt = nvm_image[matrix_io_pkg::VIRT_BIT_LO +:
                matrix_io_pkg::VIRT_W];

        if (start_det)
        begin
            c_nxt.st = matrix_io_pkg::ST_ADDR;
            c_nxt.bitcnt = 4'h0;
            c_nxt.ptr_ok = 1'b0;
            c_nxt.sda_drv = 1'b0;
        end
        else if (stop_det)
        begin
            c_nxt.st = matrix_io_pkg::ST_IDLE;
            c_nxt.sda_drv = 1'b0;
        end
        else
        begin
            unique case (c_r.st)
                matrix_io_pkg::ST_IDLE:
                begin
                    c_nxt.sda_drv = 1'b0;
                end
                matrix_io_pkg::ST_ADDR, matrix_io_pkg::ST_WRITE:
                begin
                    if (scl_rise)
                    begin
                        c_nxt.shreg = {c_r.shreg[6:0], sda_s};
                        c_nxt.bitcnt = c_r.bitcnt + 4'h1;
                    end
                    else if (scl_fall &&
                        c_r.bitcnt == matrix_io_pkg::BYTE_BITS)
                    begin
                        c_nxt.bitcnt = 4'h0;
                        c_nxt.st = matrix_io_pkg::ST_ACK;
                        c_nxt.sda_drv = 1'b1;
                        if (c_r.st == matrix_io_pkg::ST_ADDR)
                        begin
                            // foreign address: stay off the bus
                            if (c_r.shreg[7:1] != matrix_io_pkg::DEV_ADDR)
                            begin
                                c_nxt.st = matrix_io_pkg::ST_IDLE;
                                c_nxt.sda_drv = 1'b0;
                            end
                            c_nxt.rw = c_r.shreg[0];
                        end
                        else if (!c_r.ptr_ok)
                        begin
                            c_nxt.ptr = c_r.shreg;
                            c_nxt.ptr_ok = 1'b1;
                        end
                        else
                        begin
                            // only the virtual byte takes data
                            if (c_r.ptr == matrix_io_pkg::VIRT_BYTE)
                                c_nxt.virt = c_r.shreg;
                            c_nxt.ptr = c_r.ptr + 8'h01;
                        end
                    end
                end
                matrix_io_pkg::ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (c_r.rw)
                        begin
                            c_nxt.st = matrix_io_pkg::ST_SEND;
                            c_nxt.sda_drv = ~rd_byte[7];
                            c_nxt.shreg = {rd_byte[6:0], 1'b0};
                            c_nxt.bitcnt = 4'h1;
                            c_nxt.ptr = c_r.ptr + 8'h01;
                        end
                        else
                        begin
                            c_nxt.st = matrix_io_pkg::ST_WRITE;
                            c_nxt.sda_drv = 1'b0;
                        end
                    end
                end
                matrix_io_pkg::ST_SEND:
                begin
                    if (scl_fall)
                    begin
                        if (c_r.bitcnt == matrix_io_pkg::BYTE_BITS)
                        begin
                            c_nxt.st = matrix_io_pkg::ST_MACK;
                            c_nxt.sda_drv = 1'b0;
                        end
                        else
                        begin
                            c_nxt.sda_drv = ~c_r.shreg[7];
                            c_nxt.shreg = {c_r.shreg[6:0], 1'b0};
                            c_nxt.bitcnt = c_r.bitcnt + 4'h1;
                        end
                    end
                end
                matrix_io_pkg::ST_MACK:
                begin
                    // a not-acknowledge ends the read
                    if (scl_rise && sda_s)
                        c_nxt.st = matrix_io_pkg::ST_IDLE;
                    else if (scl_fall)
                    begin
                        c_nxt.st = matrix_io_pkg::ST_SEND;
                        c_nxt.sda_drv = ~rd_byte[7];
                        c_nxt.shreg = {rd_byte[6:0], 1'b0};
                        c_nxt.bitcnt = 4'h1;
                        c_nxt.ptr = c_r.ptr + 8'h01;
                    end
                end
                default:
                begin
                    c_nxt.st = matrix_io_pkg::ST_IDLE;
                    c_nxt.sda_drv = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            c_r <= '0;
            c_r.st <= matrix_io_pkg::ST_IDLE;
            c_r.virt <= matrix_io_pkg::VIRT_RESET;
            c_r.scl_q <= 1'b1;
            c_r.sda_q <= 1'b1;
        end
        else
            c_r <= c_nxt;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign sda_out = 1'b0;
    assign sda_oe = c_r.sda_drv;
    assign virtual_inputs = c_r.virt;

endmodule : matrix_select_and_virtual_io

// [inc/matrix_io_pkg.sv]
/*
 * Constants for the matrix selector and virtual I/O block: bit image
 * layout, selector field positions, serial target address and states.
 * Assumes the configuration image is stable once the power-up load ends.
 */
package matrix_io_pkg;

    // ----------------------------------------------------------------
    // image layout
    // ----------------------------------------------------------------
    localparam int IMAGE_BITS = 640;
    localparam int FIELD_W = 6;
    localparam int MATRIX_INS = 64;
    localparam int FIRST_FIELD = 67;
    localparam int LAST_FIELD = 94;
    localparam int NUM_FIELDS = LAST_FIELD - FIRST_FIELD + 1;

    // ----------------------------------------------------------------
    // matrix output numbers of named destinations
    // ----------------------------------------------------------------
    localparam int MO_BYTE_CELL_IN1 = 67;
    localparam int MO_WIDE_IN2 = 74;
    localparam int MO_WIDE_IN3 = 75;
    localparam int MO_CMP0_PD = 86;
    localparam int MO_CMP1_PD = 87;
    localparam int MO_PDLY_IN = 89;
    localparam int MO_OSCILLATOR_ZERO_EN = 90;
    localparam int MO_OSCILLATOR_ONE_EN = 91;
    localparam int MO_TEMP_PD = 92;
    localparam int MO_BG_PD = 93;

    // ----------------------------------------------------------------
    // virtual inputs and output snapshot
    // ----------------------------------------------------------------
    localparam int VIRT_BIT_LO = 608;
    localparam int VIRT_W = 8;
    localparam int VIRT_MATRIX_IN = 32;
    localparam int SNAP_BIT_LO = 576;
    localparam int SNAP_W = 64;
    localparam logic [7:0] VIRT_BYTE = 8'(VIRT_BIT_LO / 8);
    localparam logic [7:0] SNAP_BYTE_LO = 8'(SNAP_BIT_LO / 8);
    localparam logic [7:0] SNAP_BYTE_HI = 8'((SNAP_BIT_LO + SNAP_W) / 8 - 1);
    localparam logic [7:0] VIRT_RESET = 8'h00;

    // ----------------------------------------------------------------
    // serial target
    // ----------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR = 7'h4C;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_ACK   = 3'h3,
        ST_WRITE = 3'h2,
        ST_SEND  = 3'h7,
        ST_MACK  = 3'h6
    } link_state_e;

endpackage : matrix_io_pkg

// [verilog/pin_sync.sv]
/*
 * Two-stage synchroniser for pin levels.
 * Assumes inputs are asynchronous levels; only stage two is read.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic sys_clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic [WIDTH-1:0] pin_in, // raw pin levels
    output logic [WIDTH-1:0] pin_sync_q // synchronised levels
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_s;

    sync_s s_r;
    sync_s s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.meta = pin_in;
        s_nxt.stable = s_r.meta;
    end

    // idle bus level is high, so reset to ones
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            s_r <= '1;
        else
            s_r <= s_nxt;
    end

    assign pin_sync_q = s_r.stable;

endmodule : pin_sync

// [verilog/route_mux.sv]
/*
 * One connection matrix selector: a field value picks one matrix input.
 * Assumes the selector field is static configuration.
 */
`timescale 1ns/1ps
module route_mux #(
    parameter int SEL_W = 6
) (
    input wire logic sys_clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic [SEL_W-1:0] sel, // selector field
    input wire logic [(1<<SEL_W)-1:0] matrix_in, // matrix inputs
    output logic route_q // routed signal, registered
);
    typedef struct packed {
        logic routed;
    } mux_s;

    mux_s m_r;
    mux_s m_nxt;

    always_comb
    begin
        m_nxt = m_r;
        m_nxt.routed = matrix_in[sel];
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            m_r <= '0;
        else
            m_r <= m_nxt;
    end

    assign route_q = m_r.routed;

endmodule : route_mux

// [bench/serial_host.sv]
/*
 * Behavioural two-wire bus master used to reach the block's registers.
 * Assumes a pull-up on the data line that is resolved in the testbench.
 */
`timescale 1ns/1ps
module serial_host #(
    parameter int HALF = 10
) (
    input wire logic sys_clk, // system clock
    output logic scl, // serial clock level
    output logic pull, // high while pulling data low
    input wire logic sda_line // resolved data level
);
    // ------------------------------------------------------------
    // bit and byte tasks
    // ------------------------------------------------------------
    initial
    begin
        scl <= 1'b1;
        pull <= 1'b0;
    end

    // quarter of a bit; the device needs clock low above 5 cycles
    task automatic wq();
        repeat (HALF) @(posedge sys_clk);
    endtask : wq

    // also serves as repeated start once clock is low
    task automatic start();
        pull <= 1'b0;
        wq();
        scl <= 1'b1;
        wq();
        pull <= 1'b1;
        wq();
        scl <= 1'b0;
        wq();
    endtask : start

    task automatic stop();
        pull <= 1'b1;
        wq();
        scl <= 1'b1;
        wq();
        pull <= 1'b0;
        wq();
    endtask : stop

    task automatic put_bit(input logic b);
        pull <= !b;
        wq();
        scl <= 1'b1;
        wq();
        wq();
        scl <= 1'b0;
        wq();
    endtask : put_bit

    task automatic get_bit(output logic b);
        pull <= 1'b0;
        wq();
        scl <= 1'b1;
        wq();
        b = sda_line;
        wq();
        scl <= 1'b0;
        wq();
    endtask : get_bit

    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        get_bit(b);
        ack = !b;
    endtask : send

    task automatic recv(output logic [7:0] d, input logic last);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            get_bit(b);
            d[i] = b;
        end
        put_bit(last);
    endtask : recv
endmodule : serial_host

// [bench/matrix_io_chk.sv]
/*
 * Assertions on routing, virtual bits and acknowledge timing.
 * Assumes it sees only the top module's ports; bound at the foot.
 */
`timescale 1ns/1ps
module matrix_io_chk (
    input wire logic sys_clk, // system clock
    input wire logic reset, // async reset
    input wire logic scl_in, // serial clock
    input wire logic sda_oe, // data drive enable
    input wire logic [639:0] nvm_image, // configuration image
    input wire logic nvm_loaded, // load pulse
    input wire logic [63:0] macrocell_out, // cell outputs
    input wire logic [7:0] virtual_inputs, // virtual bits
    input wire logic byte_cell_in1, // output 67
    input wire logic wide_cell_in2, // output 74
    input wire logic wide_cell_in3, // output 75
    input wire logic fast_comparator_zero_pd, // output 86
    input wire logic fast_comparator_one_pd, // output 87
    input wire logic delay_edge_in, // output 89
    input wire logic oscillator_zero_en, // output 90
    input wire logic oscillator_one_en, // output 91
    input wire logic temp_sensor_pd, // output 92
    input wire logic bandgap_reference_pd // output 93
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic [63:0] mi;
    logic live_r;
    assign mi = {macrocell_out[63:40], virtual_inputs, macrocell_out[31:0]};

    // first edge after reset still shows reset-time outputs
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            live_r <= 1'b0;
        else
            live_r <= 1'b1;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_byte_cell_route: assert property (
        live_r |-> byte_cell_in1 == $past(mi[nvm_image[407:402]]))
        else $error("byte cell input one misrouted");
    a_wide_two_route: assert property (
        live_r |-> wide_cell_in2 == $past(mi[nvm_image[449:444]]))
        else $error("wide cell input two misrouted");
    a_wide_three_route: assert property (
        live_r |-> wide_cell_in3 == $past(mi[nvm_image[455:450]]))
        else $error("wide cell input three misrouted");
    a_cmp_pd_route: assert property (
        live_r |-> fast_comparator_zero_pd == $past(mi[nvm_image[521:516]])
        && fast_comparator_one_pd == $past(mi[nvm_image[527:522]]))
        else $error("comparator power-down misrouted");
    a_osc_en_route: assert property (
        live_r |-> oscillator_zero_en == $past(mi[nvm_image[545:540]])
        && oscillator_one_en == $past(mi[nvm_image[551:546]]))
        else $error("oscillator enable misrouted");
    a_pd_ref_route: assert property (
        live_r |-> bandgap_reference_pd == $past(mi[nvm_image[563:558]])
        && temp_sensor_pd == $past(mi[nvm_image[557:552]]))
        else $error("bandgap or sensor power-down misrouted");
    a_delay_in_route: assert property (
        live_r |-> delay_edge_in == $past(mi[nvm_image[539:534]]))
        else $error("delay input misrouted");
    a_virt_load: assert property (
        nvm_loaded |=> virtual_inputs == $past(nvm_image[615:608]))
        else $error("virtual bits not loaded from image");
    a_virt_quiet: assert property (
        scl_in [*8] |-> $stable(virtual_inputs) || $past(nvm_loaded))
        else $error("virtual bits changed without a write");
    a_ack_scl_low: assert property (
        $rose(sda_oe) |-> !scl_in)
        else $error("data line driven while clock high");

    c_load: cover property (nvm_loaded);
    c_ack: cover property ($rose(sda_oe));
    c_bus_write: cover property ($changed(virtual_inputs) && !nvm_loaded);
endmodule : matrix_io_chk

bind matrix_select_and_virtual_io matrix_io_chk matrix_io_chk_inst (
    .sys_clk(sys_clk),
    .reset(reset),
    .scl_in(scl_in),
    .sda_oe(sda_oe),
    .nvm_image(nvm_image),
    .nvm_loaded(nvm_loaded),
    .macrocell_out(macrocell_out),
    .virtual_inputs(virtual_inputs),
    .byte_cell_in1(byte_cell_in1),
    .wide_cell_in2(wide_cell_in2),
    .wide_cell_in3(wide_cell_in3),
    .fast_comparator_zero_pd(fast_comparator_zero_pd),
    .fast_comparator_one_pd(fast_comparator_one_pd),
    .delay_edge_in(delay_edge_in),
    .oscillator_zero_en(oscillator_zero_en),
    .oscillator_one_en(oscillator_one_en),
    .temp_sensor_pd(temp_sensor_pd),
    .bandgap_reference_pd(bandgap_reference_pd)
);

// [bench/tb_top.sv]
/*
 * Self-checking bench: routing sweep, image load, bus writes and reads.
 * Assumes the serial host model and the bound checker are compiled.
 */
`timescale 1ns/1ps
module tb_top;
    localparam logic [63:0] PAT = 64'hA5C3_0F96_3C5A_E718;
    localparam logic [7:0] ADDR_W = {matrix_io_pkg::DEV_ADDR, 1'b0};
    localparam logic [7:0] ADDR_R = {matrix_io_pkg::DEV_ADDR, 1'b1};
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [639:0] nvm_image = '0;
    logic nvm_loaded = 1'b0;
    logic [63:0] macrocell_out = PAT;
    logic [7:0] virt_exp = 8'h00;
    int tap_k [10] = '{0, 7, 8, 19, 20, 22, 23, 24, 25, 26};
    int fail_count = 0;
    int checked = 0;
    wire scl_line;
    wire host_pull;
    wire sda_oe;
    wire sda_out;
    wire sda_line;
    wire [7:0] virtual_inputs;
    wire [27:0] route_bus;
    wire [9:0] taps;

    // open drain with pull-up: low if either side pulls
    assign sda_line = !host_pull && (!sda_oe || sda_out);
    always #25 sys_clk = ~sys_clk;

    serial_host serial_host_inst (.sys_clk(sys_clk), .scl(scl_line),
        .pull(host_pull), .sda_line(sda_line));

    matrix_select_and_virtual_io matrix_select_and_virtual_io_inst (
        .sys_clk(sys_clk), .reset(reset), .scl_in(scl_line),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .nvm_image(nvm_image), .nvm_loaded(nvm_loaded),
        .macrocell_out(macrocell_out), .virtual_inputs(virtual_inputs),
        .route_bus(route_bus), .byte_cell_in1(taps[0]),
        .wide_cell_in2(taps[1]), .wide_cell_in3(taps[2]),
        .fast_comparator_zero_pd(taps[3]), .fast_comparator_one_pd(taps[4]),
        .delay_edge_in(taps[5]), .oscillator_zero_en(taps[6]),
        .oscillator_one_en(taps[7]), .temp_sensor_pd(taps[8]),
        .bandgap_reference_pd(taps[9]));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [63:0] live();
        return {macrocell_out[63:40], virt_exp, macrocell_out[31:0]};
    endfunction : live

    task automatic tx(input logic [7:0] d, input logic ack_exp);
        logic a;
        serial_host_inst.send(d, a);
        check(64'(a), 64'(ack_exp));
    endtask : tx

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_load();
        @(posedge sys_clk);
        nvm_loaded <= 1'b1;
        @(posedge sys_clk);
        nvm_loaded <= 1'b0;
        virt_exp = 8'hC3;
        @(posedge sys_clk);
        #1;
        check(64'(virtual_inputs), 64'(virt_exp));
    endtask : t_load

    // every field walks n of its 64 values (all of them when n is 64), each a different one per step
    task automatic t_route(input int n);
        logic [63:0] m;
        logic [27:0] e;
        logic [9:0] et;
        for (int v = 0; v < n; v++)
        begin
            @(posedge sys_clk);
            for (int k = 0; k < 28; k++)
                nvm_image[6*(67+k) +: 6] <= 6'((v + k) % 64);
            macrocell_out <= v[0] ? ~PAT : PAT;
            repeat (3) @(posedge sys_clk);
            #1;
            m = live();
            for (int k = 0; k < 28; k++)
                e[k] = m[(v + k) % 64];
            for (int k = 0; k < 10; k++)
                et[k] = e[tap_k[k]];
            check(64'(route_bus), 64'(e));
            check(64'(taps), 64'(et));
        end
    endtask : t_route

    // bytes either side of the virtual byte must be dropped
    task automatic t_write();
        serial_host_inst.start();
        tx(ADDR_W, 1'b1);
        tx(8'd75, 1'b1);
        tx(8'hFF, 1'b1);
        tx(8'h5A, 1'b1);
        check(64'(virtual_inputs), 64'h5A);
        tx(8'h00, 1'b1);
        serial_host_inst.stop();
        virt_exp = 8'h5A;
        check(64'(virtual_inputs), 64'(virt_exp));
    endtask : t_write

    task automatic t_read(input logic [7:0] ptr, input int n);
        logic [7:0] d;
        logic [7:0] p;
        logic [7:0] e;
        logic [63:0] m;
        serial_host_inst.start();
        tx(ADDR_W, 1'b1);
        tx(ptr, 1'b1);
        serial_host_inst.start();
        tx(ADDR_R, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            serial_host_inst.recv(d, i == n - 1);
            m = live();
            p = ptr + 8'(i);
            // image below the live view, nothing past its end
            if (p < matrix_io_pkg::SNAP_BYTE_LO)
                e = nvm_image[8*p +: 8];
            else if (p <= matrix_io_pkg::SNAP_BYTE_HI)
                e = m[8*(p-matrix_io_pkg::SNAP_BYTE_LO) +: 8];
            else
                e = 8'h00;
            check(64'(d), 64'(e));
        end
        serial_host_inst.stop();
    endtask : t_read

    task automatic t_foreign();
        serial_host_inst.start();
        tx(ADDR_W + 8'h02, 1'b0);
        serial_host_inst.stop();
        check(64'(virtual_inputs), 64'(virt_exp));
    endtask : t_foreign

    initial
    begin
        nvm_image[615:608] <= 8'hC3;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        t_load();
        t_read(8'd76, 1);
        t_route(64);
        t_write();
        t_read(8'd70, 11);
        t_foreign();
        t_route(8);
        results();
    end
endmodule : tb_top
